/* File: logic/bpb_defs.svh */
/*
  constants for the eight-pin bidirectional port: register offsets, reset values, pin roles.
  assumes inclusion by bare name from the package and the port module.
*/
`ifndef BPB_DEFS_SVH
`define BPB_DEFS_SVH

`define BPB_ADDR_W 9
`define BPB_OFS_PIN_VALUE 9'h00D
`define BPB_OFS_DIRECTION 9'h08D
`define BPB_OFS_OUTPUT_LATCH 9'h10D
`define BPB_OFS_ANALOG_SELECT 9'h18D
`define BPB_OFS_DEBUG_ENABLE 9'h1F0
`define BPB_DIRECTION_RESET 8'hFF
`define BPB_ANALOG_RESET 8'h3F
`define BPB_ANALOG_MASK 8'h3F
`define BPB_LATCH_ONLY_PINS 8'h37
`define BPB_PIN_CAPCMP 3
`define BPB_PIN_DBG_CLK 6
`define BPB_PIN_DBG_DATA 7

`endif

/* File: logic/bpb_pkg.sv */
/*
  types shared by the port: packed pin group and the module state.
  assumes bpb_defs.svh is on the include path.
*/
`include "bpb_defs.svh"

package bpb_pkg;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } bpb_pins_t;

  typedef enum logic [1:0] {
    BPB_RUN = 2'h1,
    BPB_HOLD = 2'h2
  } bpb_mode_t;

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] direction;
    logic [7:0] output_latch;
    logic [7:0] analog_select;
    logic debug_enable;
    logic [7:0] rdata;
    bpb_mode_t mode;
    bpb_pins_t pins;
  } bpb_state_t;

endpackage

/* File: logic/bpb_port.sv */
/*
  eight-pin bidirectional port with direction, output latch, pin readback and analog select.
  assumes a single-cycle register strobe master on clk and a bench that resolves the pad wires.
*/
// Added by the designer: the plain strobed port.
// What this block does
// - eight independent pins, each a digital input or output under software control
// - direction bit one puts the pin driver in high impedance
// - direction bit zero drives the pin from its output latch bit
// - reading the pin value register returns sampled pin levels, not the latch
// - writing the pin value register merges written bits into pin levels into latch
// - direction bits still steer drivers on analog pins; software keeps them set
// - analog select one makes the pin value read and digital_in of that pin return zero; pin_level stays raw
// - analog select never affects digital output driving
// - analog select bits 5 to 0 come up as one after every reset
// - with several outputs enabled, the highest priority function owns the pin
// - pin 3 capture/compare, pin 6 debug clock, pin 7 debug data, rest latch
// - input functions keep receiving pin levels while the pin is an output
// - analog select bits 7 and 6 read zero; only 5 to 0 writable
// - output latch has no reset value and keeps its content across resets
`include "bpb_defs.svh"

module bpb_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`BPB_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic capcmp_out,
  input wire logic capcmp_oe,
  input wire logic dbg_clk_out,
  input wire logic dbg_clk_oe,
  input wire logic dbg_data_out,
  input wire logic dbg_data_oe,
  output logic [7:0] digital_in,
  output logic [7:0] pin_level
);

  bpb_pkg::bpb_state_t state;
  bpb_pkg::bpb_state_t next_state;
  logic [7:0] digital_view;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // analog pins read zero on the pin value read and digital_in; pin_level stays raw
  assign digital_view = state.sync2 & ~state.analog_select;

  always_comb begin
    next_state = state;
    next_state.sync1 = pin_in;
    next_state.sync2 = state.sync1;
    next_state.rdata = 8'h00;
    next_state.mode = bpb_pkg::BPB_RUN;
    if (wr) begin
      case (addr)
        `BPB_OFS_PIN_VALUE: begin
          // a full-byte write replaces every pin bit, so the merge is the written byte
          next_state.output_latch = wdata;
        end
        `BPB_OFS_DIRECTION: begin
          next_state.direction = wdata;
        end
        `BPB_OFS_OUTPUT_LATCH: begin
          next_state.output_latch = wdata;
        end
        `BPB_OFS_ANALOG_SELECT: begin
          next_state.analog_select = wdata & `BPB_ANALOG_MASK;
        end
        `BPB_OFS_DEBUG_ENABLE: begin
          next_state.debug_enable = wdata[0];
        end
        default: begin
          next_state.mode = bpb_pkg::BPB_HOLD;
        end
      endcase
    end
    if (rd) begin
      case (addr)
        `BPB_OFS_PIN_VALUE: next_state.rdata = digital_view;
        `BPB_OFS_DIRECTION: next_state.rdata = state.direction;
        `BPB_OFS_OUTPUT_LATCH: next_state.rdata = state.output_latch;
        `BPB_OFS_ANALOG_SELECT: next_state.rdata = state.analog_select;
        `BPB_OFS_DEBUG_ENABLE: next_state.rdata = {7'h00, state.debug_enable};
        default: next_state.rdata = 8'h00;
      endcase
    end
    // direction decides the drivers before the pin 3, 6 and 7 overrides, analog select is not consulted
    next_state.pins.oe = ~next_state.direction;
    next_state.pins.out = next_state.output_latch;
    if (capcmp_oe) begin
      next_state.pins.oe[`BPB_PIN_CAPCMP] = 1'b1;
      next_state.pins.out[`BPB_PIN_CAPCMP] = capcmp_out;
    end
    if (next_state.debug_enable && dbg_clk_oe) begin
      next_state.pins.oe[`BPB_PIN_DBG_CLK] = 1'b1;
      next_state.pins.out[`BPB_PIN_DBG_CLK] = dbg_clk_out;
    end
    if (next_state.debug_enable && dbg_data_oe) begin
      next_state.pins.oe[`BPB_PIN_DBG_DATA] = 1'b1;
      next_state.pins.out[`BPB_PIN_DBG_DATA] = dbg_data_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state.sync1 <= 8'h00;
      state.sync2 <= 8'h00;
      state.direction <= `BPB_DIRECTION_RESET;
      state.analog_select <= `BPB_ANALOG_RESET;
      state.debug_enable <= 1'b0;
      state.rdata <= 8'h00;
      state.mode <= bpb_pkg::BPB_RUN;
      state.pins.oe <= 8'h00;
      state.pins.out <= 8'h00;
      // latch keeps running through reset, content survives it
      state.output_latch <= next_state.output_latch;
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;
  assign pin_out = state.pins.out;
  assign pin_oe = state.pins.oe;
  // peripheral inputs see the pad even while it drives
  assign digital_in = digital_view;
  assign pin_level = state.sync2;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_read_pin;
    @(posedge clk) disable iff (!rst_n)
      rd && addr == `BPB_OFS_PIN_VALUE |=> rdata == $past(state.sync2 & ~state.analog_select);
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("pin read wrong");

  property p_analog_zero;
    @(posedge clk) disable iff (!rst_n)
      (digital_in & state.analog_select) == 8'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin reads one");

  property p_rmw;
    @(posedge clk) disable iff (!rst_n)
      wr && addr == `BPB_OFS_PIN_VALUE |=> state.output_latch == $past(wdata);
  endproperty
  a_rmw: assert property (p_rmw) else $error("port write lost");

  property p_low_pins;
    @(posedge clk) disable iff (!rst_n)
      pin_oe[5:0] == ~state.direction[5:0] || pin_oe[3];
  endproperty
  a_low_pins: assert property (p_low_pins) else $error("driver mismatch");

  property p_latch_drive;
    @(posedge clk) disable iff (!rst_n)
      !state.direction[0] |-> pin_oe[0] && pin_out[0] == state.output_latch[0];
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("latch not driven");

  property p_capcmp;
    @(posedge clk) disable iff (!rst_n)
      rst_n && capcmp_oe ##1 rst_n |-> pin_oe[3] && pin_out[3] == $past(capcmp_out);
  endproperty
  a_capcmp: assert property (p_capcmp) else $error("pin 3 priority");

  property p_debug_gate;
    @(posedge clk) disable iff (!rst_n)
      !state.debug_enable && state.direction[7] |-> !pin_oe[7];
  endproperty
  a_debug_gate: assert property (p_debug_gate) else $error("debug override leak");

  property p_analog_top;
    @(posedge clk) disable iff (!rst_n)
      state.analog_select[7:6] == 2'h0;
  endproperty
  a_analog_top: assert property (p_analog_top) else $error("analog bits 7:6 set");

  property p_analog_reset;
    @(posedge clk) !rst_n |=> state.analog_select == `BPB_ANALOG_RESET;
  endproperty
  a_analog_reset: assert property (p_analog_reset) else $error("analog reset");

  property p_dir_write;
    @(posedge clk) disable iff (!rst_n)
      wr && addr == `BPB_OFS_DIRECTION |=> state.direction == $past(wdata);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_latch_write;
    @(posedge clk) disable iff (!rst_n)
      wr && addr == `BPB_OFS_OUTPUT_LATCH |=> state.output_latch == $past(wdata);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");

  property p_analog_write;
    @(posedge clk) disable iff (!rst_n)
      wr && addr == `BPB_OFS_ANALOG_SELECT |=>
        state.analog_select == ($past(wdata) & `BPB_ANALOG_MASK);
  endproperty
  a_analog_write: assert property (p_analog_write) else $error("analog write wrong");

  property p_read_dir;
    @(posedge clk) disable iff (!rst_n)
      rd && addr == `BPB_OFS_DIRECTION |=> rdata == $past(state.direction);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("direction read wrong");

  property p_read_latch;
    @(posedge clk) disable iff (!rst_n)
      rd && addr == `BPB_OFS_OUTPUT_LATCH |=> rdata == $past(state.output_latch);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("latch read wrong");

  property p_read_analog;
    @(posedge clk) disable iff (!rst_n)
      rd && addr == `BPB_OFS_ANALOG_SELECT |=> rdata[7:6] == 2'h0;
  endproperty
  a_read_analog: assert property (p_read_analog) else $error("analog top bits read");

  property p_debug_read;
    @(posedge clk) disable iff (!rst_n)
      rd && addr == `BPB_OFS_DEBUG_ENABLE |=> rdata[7:1] == 7'h00;
  endproperty
  a_debug_read: assert property (p_debug_read) else $error("debug enable read wrong");

  // read data stand one cycle only, so a stale byte never looks like a fresh read
  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_n)
      !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers");

  property p_input_hiz;
    @(posedge clk) disable iff (!rst_n)
      (pin_oe & state.direction & `BPB_LATCH_ONLY_PINS) == 8'h00;
  endproperty
  a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");

  property p_output_drive;
    @(posedge clk) disable iff (!rst_n)
      (pin_oe & `BPB_LATCH_ONLY_PINS) == (~state.direction & `BPB_LATCH_ONLY_PINS);
  endproperty
  a_output_drive: assert property (p_output_drive) else $error("output pin idle");

  property p_output_value;
    @(posedge clk) disable iff (!rst_n)
      ((pin_out ^ state.output_latch) & ~state.direction & `BPB_LATCH_ONLY_PINS) == 8'h00;
  endproperty
  a_output_value: assert property (p_output_value) else $error("pin value not latch");

  property p_analog_drive;
    @(posedge clk) disable iff (!rst_n)
      !state.direction[0] && state.analog_select[0] |-> pin_oe[0];
  endproperty
  a_analog_drive: assert property (p_analog_drive) else $error("analog pin not driven");

  property p_capcmp_release;
    @(posedge clk) disable iff (!rst_n)
      !capcmp_oe ##1 state.direction[3] |-> !pin_oe[3];
  endproperty
  a_capcmp_release: assert property (p_capcmp_release) else $error("pin 3 held");

  property p_dbg_clk;
    @(posedge clk) disable iff (!rst_n)
      dbg_clk_oe ##1 state.debug_enable |-> pin_oe[6] && pin_out[6] == $past(dbg_clk_out);
  endproperty
  a_dbg_clk: assert property (p_dbg_clk) else $error("pin 6 priority");

  property p_dbg_data;
    @(posedge clk) disable iff (!rst_n)
      dbg_data_oe ##1 state.debug_enable |-> pin_oe[7] && pin_out[7] == $past(dbg_data_out);
  endproperty
  a_dbg_data: assert property (p_dbg_data) else $error("pin 7 priority");

  property p_dbg_clk_gate;
    @(posedge clk) disable iff (!rst_n)
      !state.debug_enable && state.direction[6] |-> !pin_oe[6];
  endproperty
  a_dbg_clk_gate: assert property (p_dbg_clk_gate) else $error("pin 6 override leak");

  // two flops of latency: the pad level seen now was on the pin two edges ago
  property p_pin_sync;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && $past(rst_n, 2) |-> pin_level == $past(pin_in, 2);
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin level stale");

  property p_din_mask;
    @(posedge clk) disable iff (!rst_n)
      digital_in == (pin_level & ~state.analog_select);
  endproperty
  a_din_mask: assert property (p_din_mask) else $error("digital input mask");

  property p_unmapped_hold;
    @(posedge clk) disable iff (!rst_n)
      state.mode == bpb_pkg::BPB_HOLD |->
        $stable(state.direction) && $stable(state.analog_select) && $stable(state.debug_enable);
  endproperty
  a_unmapped_hold: assert property (p_unmapped_hold) else $error("unmapped write landed");

  property p_mode_run;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !wr |=> state.mode == bpb_pkg::BPB_RUN;
  endproperty
  a_mode_run: assert property (p_mode_run) else $error("mode stuck");

  property p_dir_stable;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !(wr && addr == `BPB_OFS_DIRECTION) |=> $stable(state.direction);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction drifted");

  property p_an_stable;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !(wr && addr == `BPB_OFS_ANALOG_SELECT) |=> $stable(state.analog_select);
  endproperty
  a_an_stable: assert property (p_an_stable) else $error("analog select drifted");

  property p_reset_dir;
    @(posedge clk) !rst_n |=>
      state.direction == `BPB_DIRECTION_RESET && !state.debug_enable && pin_oe == 8'h00;
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("reset drivers");

  property p_reset_rdata;
    @(posedge clk) !rst_n |=> rdata == 8'h00;
  endproperty
  a_reset_rdata: assert property (p_reset_rdata) else $error("reset read data");

  c_rmw: cover property (@(posedge clk) wr && addr == `BPB_OFS_PIN_VALUE);
  c_read: cover property (@(posedge clk) rd && addr == `BPB_OFS_PIN_VALUE ##1 rdata != 8'h00);
  c_dbg: cover property (@(posedge clk) state.debug_enable && dbg_data_oe);
  c_cap: cover property (@(posedge clk) capcmp_oe && state.direction[3]);
  c_hold: cover property (@(posedge clk) state.mode == bpb_pkg::BPB_HOLD);

endmodule

/* File: test/bpb_pad_model.sv */
/*
  pad model of the circuitry beyond the port: resolves each pin from the port driver and
  an external driver. assumes the bench never drives a pin that the port drives.
*/
module bpb_pad_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin has no pull: it wanders every cycle so a stale value never passes
  logic [7:0] float = 8'h5A;
  always @(posedge clk) float <= ~float;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & float)));
endmodule

/* File: test/bidirectional_port_b_tb.sv */
/*
  self-checking bench for the port: register tasks, random and corner scenarios.
  assumes bpb_defs.svh on the include path and the pad model beside the port.
*/
`include "bpb_defs.svh"
module bidirectional_port_b_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] A_PV = `BPB_OFS_PIN_VALUE;
  localparam logic [8:0] A_DR = `BPB_OFS_DIRECTION;
  localparam logic [8:0] A_LT = `BPB_OFS_OUTPUT_LATCH;
  localparam logic [8:0] A_AN = `BPB_OFS_ANALOG_SELECT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] ov = 6'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] rdata, pin_in, pin_out, pin_oe, digital_in, pin_level, v, e, lat, r;
  logic [15:0] lfsr = 16'h9D2E;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  bpb_port u_bpb_port (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .capcmp_out(ov[0]), .capcmp_oe(ov[1]), .dbg_clk_out(ov[2]), .dbg_clk_oe(ov[3]),
    .dbg_data_out(ov[4]), .dbg_data_oe(ov[5]), .digital_in(digital_in), .pin_level(pin_level));
  bpb_pad_model u_bpb_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("oe_rst", pin_oe, 8'h00);
    rd_reg(A_AN, r); chk("an_rst", r, 8'h3F);
    wr_reg(A_AN, 8'hFF); rd_reg(A_AN, r); chk("an_mask", r, 8'h3F);
    wr_reg(9'h001, 8'h55);
    rd_reg(9'h001, r); chk("unmapped", r, 8'h00);
    wr_reg(A_AN, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      lat = rnd();
      e = rnd();
      // the outside drives only pins that the port leaves as inputs
      ext_en <= v;
      ext_val <= e;
      wr_reg(A_LT, lat);
      wr_reg(A_DR, v);
      chk("oe", pin_oe, ~v);
      chk("drive", pin_out & ~v, lat & ~v);
      repeat (2) @(posedge clk);
      rd_reg(A_PV, r); chk("pins", r, (~v & lat) | (v & e));
      chk("level", pin_level, (~v & lat) | (v & e));
    end
    wr_reg(A_DR, 8'hFF);
    wr_reg(A_AN, 8'h3F);
    ext_en <= 8'hFF;
    ext_val <= 8'hA5;
    repeat (3) @(posedge clk);
    rd_reg(A_PV, r); chk("an_read", r, 8'h80);
    chk("an_din", digital_in, 8'h80);
    chk("an_level", pin_level, 8'hA5);
    ext_en <= 8'h00;
    wr_reg(A_DR, 8'h00);
    wr_reg(A_PV, 8'h3C);
    rd_reg(A_LT, r); chk("rmw", r, 8'h3C);
    chk("an_drive", pin_out, 8'h3C);
    ov <= 6'b111110;
    repeat (2) @(posedge clk);
    #1 chk("ccp", pin_out, 8'h34);
    wr_reg(9'h1F0, 8'h01);
    @(posedge clk);
    #1 chk("dbg", pin_out, 8'hF4);
    wr_reg(A_DR, 8'hFF);
    @(posedge clk);
    #1 chk("ovr_oe", pin_oe, 8'hC8);
    ov <= 6'h00;
    wr_reg(A_AN, 8'h00);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("oe_rst2", pin_oe, 8'h00);
    rd_reg(A_LT, r); chk("lat_keep", r, 8'h3C);
    rd_reg(A_AN, r); chk("an_rst2", r, 8'h3F);
    print_verdict();
  end
endmodule
